// ==== design/lsc_consts.svh ====
`ifndef LSC_CONSTS_SVH
`define LSC_CONSTS_SVH

// Clock and timing
`define LSC_CLK_MHZ        40
`define LSC_GLITCH_NS      80
`define LSC_GLITCH_CYC     ((`LSC_GLITCH_NS * `LSC_CLK_MHZ + 999) / 1000)
// One extra sample: a pulse under the limit can still cover that many edges
`define LSC_GLITCH_SMP     (`LSC_GLITCH_CYC + 1)
`define LSC_SHDN_NS        2500000
`define LSC_SHDN_CYC       ((`LSC_SHDN_NS * `LSC_CLK_MHZ + 999) / 1000)
`define LSC_TMO_NS         64'd1200000000
`define LSC_TMO_CYC        ((`LSC_TMO_NS * `LSC_CLK_MHZ) / 1000)

// Duty measurement window of 2^12 cycles
`define LSC_WIN_W          12
`define LSC_HI_W           13
`define LSC_DUTY_W         8
`define LSC_DUTY_FULL      8'hff
`define LSC_DUTY_LSB       4

// Register byte offsets
`define LSC_ADDR_W         4
`define LSC_OFF_STATUS     4'h0
`define LSC_OFF_MASK       4'h4
`define LSC_OFF_STATE      4'h8
`define LSC_OFF_CTRL       4'hc

// Event bits of status and mask
`define LSC_EVT_W          5
`define LSC_EVT_SHDN       0
`define LSC_EVT_UV         1
`define LSC_EVT_SHORT      2
`define LSC_EVT_TMO        3
`define LSC_EVT_THERM      4

// Control bits
`define LSC_CTRL_OFF       0

// Reset values
`define LSC_MASK_RST       5'h00
`define LSC_STATUS_RST     5'h00
`define LSC_CTRL_RST       1'h0

`endif

// ==== design/lsc_pkg.sv ====
package lsc_pkg;
  typedef enum logic [1:0] {
    LSC_SHDN  = 2'b00,
    LSC_RAMP  = 2'b01,
    LSC_ON    = 2'b11,
    LSC_LATCH = 2'b10
  } lsc_state_e;

  typedef logic [4:0] lsc_evt_t;
endpackage

// ==== design/lsc_en_if.sv ====
`timescale 1ns/1ps
interface lsc_en_if;
  logic en_raw;
  logic en_clean;
  logic en_rise;

  modport filt (input en_raw, output en_clean, output en_rise);
  modport core (output en_raw, input en_clean, input en_rise);
endinterface

// ==== design/lsc_deglitch.sv ====
`timescale 1ns/1ps
`include "lsc_consts.svh"
module lsc_deglitch import lsc_pkg::*; (
  input  wire logic sys_clk,
  input  wire logic rst,
  lsc_en_if.filt    enf
);
  logic       s1_r;
  logic       s2_r;
  logic       clean_r;
  logic       clean_nxt;
  logic       rise_r;
  logic       rise_nxt;
  logic [3:0] run_r;
  logic [3:0] run_nxt;

  always_comb begin
    run_nxt   = 4'h0;
    clean_nxt = clean_r;
    rise_nxt  = 1'b0;
    if (s2_r != clean_r) begin
      // Level must hold for the full sample count before it is believed
      if (run_r == 4'(`LSC_GLITCH_SMP - 1)) begin
        clean_nxt = s2_r;
        rise_nxt  = s2_r;
      end else begin
        run_nxt = run_r + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      clean_r <= 1'b0;
      rise_r  <= 1'b0;
      run_r   <= 4'h0;
    end else begin
      s1_r    <= enf.en_raw;
      s2_r    <= s1_r;
      clean_r <= clean_nxt;
      rise_r  <= rise_nxt;
      run_r   <= run_nxt;
    end
  end

  assign enf.en_clean = clean_r;
  assign enf.en_rise  = rise_r;

  deglitch_rise_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(clean_r) |-> $past(s2_r, 1) && $past(s2_r, 2) && $past(s2_r, 3)
                       && $past(s2_r, 4) && $past(s2_r, 5))
    else $error("enable accepted after a short pulse");
  deglitch_fall_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(clean_r) |-> !$past(s2_r, 1) && !$past(s2_r, 2) && !$past(s2_r, 3)
                       && !$past(s2_r, 4) && !$past(s2_r, 5))
    else $error("enable dropped after a short glitch");
endmodule

// ==== design/lsc_top.sv ====
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "lsc_consts.svh"
module lsc_top import lsc_pkg::*; #(
  parameter int unsigned SHDN_CYC = `LSC_SHDN_CYC,
  parameter int unsigned TMO_CYC  = 32'(`LSC_TMO_CYC)
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    en_pin,
  input  wire logic                    flash_sel_pin,
  input  wire logic                    uv_flag,
  input  wire logic                    short_flag,
  input  wire logic                    ot_flag,
  input  wire logic [`LSC_ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  output logic                         irq,
  output logic                         led_on,
  output logic                         sense_on,
  output logic      [`LSC_DUTY_W-1:0]  duty_cmd,
  output logic                         flash_mode,
  output logic                         shutdown
);
  lsc_en_if lif ();
  assign lif.en_raw = en_pin;

  lsc_deglitch u_deglitch (
    .sys_clk (sys_clk),
    .rst     (rst),
    .enf     (lif.filt)
  );

  logic en_clean;
  assign en_clean = lif.en_clean;

  // Pin and comparator synchronisers
  logic [3:0] flg_raw;
  logic [3:0] flg_s1_r;
  logic [3:0] flg_s2_r;
  assign flg_raw = {ot_flag, short_flag, uv_flag, flash_sel_pin};

  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        flg_s1_r[i] <= 1'b0;
        flg_s2_r[i] <= 1'b0;
      end else begin
        flg_s1_r[i] <= flg_raw[i];
        flg_s2_r[i] <= flg_s1_r[i];
      end
    end
  end

  logic flash_s;
  logic uv_s;
  logic short_s;
  logic ot_s;
  assign flash_s = flg_s2_r[0];
  assign uv_s    = flg_s2_r[1];
  assign short_s = flg_s2_r[2];
  assign ot_s    = flg_s2_r[3];

  // Operating state
  lsc_state_e  st_r;
  lsc_state_e  st_nxt;
  logic [31:0] shdn_cnt_r;
  logic [31:0] shdn_cnt_nxt;
  logic [31:0] tmo_cnt_r;
  logic [31:0] tmo_cnt_nxt;
  logic        therm_r;
  logic        therm_nxt;
  logic        tmo_r;
  logic        tmo_nxt;
  logic        arm_r;
  logic        arm_nxt;
  logic        led_nxt;
  logic        sense_nxt;
  logic        soft_off_r;
  logic        shdn_hit;
  logic        tmo_hit;
  logic        active;
  logic        active_nxt;

  assign active   = (st_r == LSC_RAMP) || (st_r == LSC_ON);
  assign shdn_hit = (st_r != LSC_SHDN) && !en_clean && (shdn_cnt_r == SHDN_CYC);
  assign tmo_hit  = active && flash_s && (tmo_cnt_r == TMO_CYC);

  always_comb begin
    st_nxt       = st_r;
    therm_nxt    = therm_r;
    tmo_nxt      = tmo_r;
    arm_nxt      = arm_r;
    shdn_cnt_nxt = 32'h0;
    tmo_cnt_nxt  = 32'h0;
    if (!en_clean && st_r != LSC_SHDN) begin
      shdn_cnt_nxt = (shdn_cnt_r == SHDN_CYC) ? shdn_cnt_r : shdn_cnt_r + 32'h1;
    end
    // Count restarts with each flash event, torch time never counts
    if (active && flash_s && tmo_cnt_r != TMO_CYC) begin
      tmo_cnt_nxt = tmo_cnt_r + 32'h1;
    end
    unique case (st_r)
      LSC_SHDN: begin
        therm_nxt = 1'b0;
        tmo_nxt   = 1'b0;
        arm_nxt   = 1'b0;
        // Hot die holds shutdown even when enable returns
        if (en_clean && !ot_s) begin
          st_nxt = LSC_RAMP;
        end
      end
      LSC_RAMP, LSC_ON: begin
        if (st_r == LSC_RAMP) begin
          arm_nxt = 1'b1;
        end
        if (shdn_hit) begin
          st_nxt = LSC_SHDN;
        end else if (ot_s) begin
          st_nxt    = LSC_LATCH;
          therm_nxt = 1'b1;
        end else if (tmo_hit) begin
          st_nxt  = LSC_LATCH;
          tmo_nxt = 1'b1;
        end else begin
          st_nxt = LSC_ON;
        end
      end
      LSC_LATCH: begin
        if (shdn_hit) begin
          st_nxt = LSC_SHDN;
        end
      end
    endcase
    // Entry into shutdown drops latched faults at once, not a cycle later
    if (st_nxt == LSC_SHDN) begin
      therm_nxt   = 1'b0;
      tmo_nxt     = 1'b0;
      tmo_cnt_nxt = 32'h0;
      arm_nxt     = 1'b0;
    end
    active_nxt = (st_nxt == LSC_RAMP) || (st_nxt == LSC_ON);
    // Undervoltage only gates the output, state and duty are kept
    led_nxt   = active_nxt && !uv_s && !soft_off_r && !(arm_nxt && short_s);
    sense_nxt = active_nxt && !uv_s && !soft_off_r && arm_nxt && short_s;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r       <= LSC_SHDN;
      shdn_cnt_r <= 32'h0;
      tmo_cnt_r  <= 32'h0;
      therm_r    <= 1'b0;
      tmo_r      <= 1'b0;
      arm_r      <= 1'b0;
      led_on     <= 1'b0;
      sense_on   <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      shdn_cnt_r <= shdn_cnt_nxt;
      tmo_cnt_r  <= tmo_cnt_nxt;
      therm_r    <= therm_nxt;
      tmo_r      <= tmo_nxt;
      arm_r      <= arm_nxt;
      led_on     <= led_nxt;
      sense_on   <= sense_nxt;
    end
  end

  assign flash_mode = flash_s;
  assign shutdown   = (st_r == LSC_SHDN);

  // Duty measurement over a fixed window
  logic [`LSC_WIN_W-1:0]  win_r;
  logic [`LSC_WIN_W-1:0]  win_nxt;
  logic [`LSC_HI_W-1:0]   hi_r;
  logic [`LSC_HI_W-1:0]   hi_nxt;
  logic [`LSC_HI_W-1:0]   hi_tot;
  logic [`LSC_DUTY_W-1:0] duty_nxt;

  always_comb begin
    win_nxt  = win_r + `LSC_WIN_W'(1);
    hi_tot   = hi_r + `LSC_HI_W'(en_clean);
    hi_nxt   = hi_tot;
    duty_nxt = duty_cmd;
    if (win_r == '1) begin
      hi_nxt = '0;
      // Continuous high gives full scale
      duty_nxt = hi_tot[`LSC_HI_W-1] ? `LSC_DUTY_FULL
                 : hi_tot[`LSC_DUTY_LSB +: `LSC_DUTY_W];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      win_r    <= '0;
      hi_r     <= '0;
      duty_cmd <= '0;
    end else begin
      win_r    <= win_nxt;
      hi_r     <= hi_nxt;
      duty_cmd <= duty_nxt;
    end
  end

  // Register file and interrupt
  logic       uv_q_r;
  logic       sense_q_r;
  lsc_evt_t   evt;
  lsc_evt_t   status_r;
  lsc_evt_t   status_nxt;
  lsc_evt_t   mask_r;
  lsc_evt_t   mask_nxt;
  logic       soft_off_nxt;
  logic [31:0] rdata_nxt;

  always_comb begin
    evt                 = '0;
    evt[`LSC_EVT_SHDN]  = (st_nxt == LSC_SHDN) && (st_r != LSC_SHDN);
    evt[`LSC_EVT_UV]    = uv_s && !uv_q_r;
    evt[`LSC_EVT_SHORT] = sense_on && !sense_q_r;
    evt[`LSC_EVT_TMO]   = tmo_nxt && !tmo_r;
    evt[`LSC_EVT_THERM] = therm_nxt && !therm_r;
    status_nxt   = status_r;
    mask_nxt     = mask_r;
    soft_off_nxt = soft_off_r;
    rdata_nxt    = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        `LSC_OFF_STATUS: begin
          rdata_nxt  = 32'(status_r);
          status_nxt = '0;
        end
        `LSC_OFF_MASK:  rdata_nxt = 32'(mask_r);
        `LSC_OFF_STATE: rdata_nxt = {16'h0, duty_cmd, 1'b0, arm_r, tmo_r, therm_r,
                                     uv_s, flash_s, st_r};
        `LSC_OFF_CTRL:  rdata_nxt = 32'(soft_off_r);
        default:        rdata_nxt = 32'h0;
      endcase
    end
    if (reg_wr) begin
      if (reg_addr == `LSC_OFF_MASK) begin
        mask_nxt = reg_wdata[`LSC_EVT_W-1:0];
      end
      if (reg_addr == `LSC_OFF_CTRL) begin
        soft_off_nxt = reg_wdata[`LSC_CTRL_OFF];
      end
    end
    // New events win over a clearing read
    status_nxt = status_nxt | evt;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      uv_q_r     <= 1'b0;
      sense_q_r  <= 1'b0;
      status_r   <= `LSC_STATUS_RST;
      mask_r     <= `LSC_MASK_RST;
      soft_off_r <= `LSC_CTRL_RST;
      reg_rdata  <= 32'h0;
    end else begin
      uv_q_r     <= uv_s;
      sense_q_r  <= sense_on;
      status_r   <= status_nxt;
      mask_r     <= mask_nxt;
      soft_off_r <= soft_off_nxt;
      reg_rdata  <= rdata_nxt;
    end
  end

  assign irq = |(status_r & mask_r);

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  shdn_entry_a: assert property (shdn_hit |=> st_r == LSC_SHDN && !led_on)
    else $error("no shutdown after long low enable");
  shdn_early_a: assert property (st_r != LSC_SHDN && en_clean |=> st_r != LSC_SHDN)
    else $error("shutdown while enable high");
  uv_off_a: assert property (uv_s |=> !led_on && !sense_on)
    else $error("LED current on during undervoltage");
  // Skip window ends, where the duty may move for its own reason
  uv_restore_a: assert property ($past(uv_s) && !uv_s && st_r == LSC_ON
    && st_nxt == LSC_ON && !soft_off_r && !(arm_r && short_s) && win_r != '1
    |=> led_on && $stable(duty_cmd))
    else $error("current not restored after undervoltage");
  short_ignore_a: assert property (st_r == LSC_SHDN |=> !arm_r && !sense_on)
    else $error("short detection armed before ramp");
  short_sense_a: assert property (arm_r && short_s && st_nxt == LSC_ON && !uv_s
    && !soft_off_r |=> sense_on && !led_on)
    else $error("shorted LED not reduced to sense current");
  short_recover_a: assert property ($fell(short_s) && st_r == LSC_ON
    && st_nxt == LSC_ON && !uv_s && !soft_off_r |=> led_on)
    else $error("current not restored after short removed");
  torch_count_a: assert property (!flash_s |=> tmo_cnt_r == 32'h0)
    else $error("timeout counting in torch mode");
  flash_tmo_a: assert property (tmo_hit && !shdn_hit && !ot_s
    |=> st_r == LSC_LATCH && tmo_r && !led_on)
    else $error("flash timeout did not cut current");
  latch_hold_a: assert property (st_r == LSC_LATCH && !shdn_hit
    |=> st_r == LSC_LATCH ##1 !led_on)
    else $error("latched fault left without shutdown");
  therm_off_a: assert property (ot_s && active && !shdn_hit |=> st_r == LSC_LATCH && therm_r)
    else $error("over temperature did not disable current");
  therm_resume_a: assert property (st_r == LSC_SHDN && ot_s |=> st_r == LSC_SHDN)
    else $error("restart while die hot");
  duty_full_a: assert property (win_r == '1 && hi_r == {1'b0, {`LSC_WIN_W{1'b1}}}
    && en_clean |=> duty_cmd == `LSC_DUTY_FULL)
    else $error("continuous high not full scale");
  shdn_clear_a: assert property (st_r == LSC_SHDN |-> !therm_r && !tmo_r
    && tmo_cnt_r == 32'h0)
    else $error("fault or timer kept through shutdown");
  rearm_a: assert property (st_r == LSC_RAMP && st_nxt == LSC_ON |=> arm_r)
    else $error("short detection not re-armed after ramp");
  rd_clear_a: assert property (reg_rd && reg_addr == `LSC_OFF_STATUS && evt == '0
    |=> status_r == '0 && reg_rdata == 32'($past(status_r)))
    else $error("status read did not return and clear");

  shdn_c: cover property (st_r == LSC_ON ##1 st_r == LSC_SHDN);
  short_c: cover property (sense_on ##[1:50] led_on);
  tmo_c: cover property (tmo_hit ##1 st_r == LSC_LATCH);
  therm_c: cover property (therm_r && shdn_hit ##1 st_r == LSC_SHDN);
  wake_c: cover property (lif.en_rise ##1 st_r == LSC_RAMP);
endmodule

// ==== test/lsc_host_model.sv ====
`timescale 1ns/1ps
module lsc_host_model (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] hi_cyc,
  input  wire logic [15:0] per_cyc,
  input  wire logic        flash_req,
  output logic             en_pin,
  output logic             flash_sel_pin
);
  // Mode 0 holds enable low, 1 holds it high, 2 runs PWM
  logic [15:0] ph_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph_r          <= 16'h0000;
      en_pin        <= 1'b0;
      flash_sel_pin <= 1'b0;
    end else begin
      flash_sel_pin <= flash_req;
      ph_r          <= (ph_r + 16'h0001 >= per_cyc) ? 16'h0000 : ph_r + 16'h0001;
      case (mode)
        2'h1: en_pin <= 1'b1;
        2'h2: en_pin <= (ph_r < hi_cyc);
        // Low long enough is the only way out of a latched fault
        default: en_pin <= 1'b0;
      endcase
    end
  end
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
`include "lsc_consts.svh"
module tb;
  import lsc_pkg::*;
  // PWM period divides the duty window, so the expected duty is exact
  localparam int unsigned SHDN = 1500;
  localparam int unsigned TMO  = 200;
  localparam int unsigned PER  = 1024;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  mode = 2'h0;
  logic [15:0] hi = 16'h0000;
  logic        flash = 1'b0;
  logic        en_pin;
  logic        flash_sel_pin;
  logic        uv = 1'b0;
  logic        shrt = 1'b0;
  logic        ot = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        irq;
  logic        led_on;
  logic        sense_on;
  logic [7:0]  duty_cmd;
  logic        flash_mode;
  logic        shutdown;
  logic [31:0] lfsr = 32'h000115be;
  logic [31:0] d;
  logic        ok;
  int          err_count = 0;
  int          checks_done = 0;

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  lsc_host_model host (.sys_clk(sys_clk), .rst(rst), .mode(mode), .hi_cyc(hi),
    .per_cyc(16'(PER)), .flash_req(flash), .en_pin(en_pin), .flash_sel_pin(flash_sel_pin));

  lsc_top #(.SHDN_CYC(SHDN), .TMO_CYC(TMO)) dut (.sys_clk(sys_clk), .rst(rst),
    .en_pin(en_pin), .flash_sel_pin(flash_sel_pin), .uv_flag(uv), .short_flag(shrt),
    .ot_flag(ot), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .led_on(led_on),
    .sense_on(sense_on), .duty_cmd(duty_cmd), .flash_mode(flash_mode),
    .shutdown(shutdown));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // High cycles in one 4096 window, scaled down, saturating at full
  function automatic logic [7:0] exp_duty(input int unsigned h);
    int unsigned v;
    v = ((h * 4096) / PER) >> 4;
    return (v > 255) ? 8'hff : 8'(v);
  endfunction

  function automatic logic pick(input int sel);
    case (sel)
      0: return led_on;
      1: return sense_on;
      default: return shutdown;
    endcase
  endfunction

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wait_sig(input int sel, input logic v, input int n);
    for (int i = 0; i < n && pick(sel) !== v; i++) begin
      @(posedge sys_clk);
      #1;
    end
  endtask

  task automatic stay(input int sel, input logic v, input int n, output logic good);
    good = 1'b1;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      if (pick(sel) !== v) good = 1'b0;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic restart;
    cyc(1);
    mode <= 2'h0;
    wait_sig(2, 1'b1, SHDN + 40);
    cyc(1);
    mode <= 2'h1;
    wait_sig(0, 1'b1, 30);
  endtask

  initial begin
    #(25ns * 80000);
    err_count++;
    complete_run();
  end

  initial begin
    cyc(5);
    rst <= 1'b0;
    cyc(1);
    #1;
    check(32'(shutdown), 32'h1);
    check(32'(led_on), 32'h0);
    rd(`LSC_OFF_MASK, d);
    check(d, 32'(`LSC_MASK_RST));
    rd(`LSC_OFF_CTRL, d);
    check(d, 32'(`LSC_CTRL_RST));
    rd(4'h2, d);
    check(d, 32'h0);
    wr(`LSC_OFF_MASK, 32'h1f);
    rd(`LSC_OFF_MASK, d);
    check(d, 32'h1f);
    // Three-cycle pulse, 75 ns, with a short present while off
    cyc(1);
    shrt <= 1'b1;
    mode <= 2'h1;
    cyc(3);
    mode <= 2'h0;
    stay(2, 1'b1, 30, ok);
    check(32'(ok), 32'h1);
    check(32'(sense_on), 32'h0);
    cyc(1);
    shrt <= 1'b0;
    mode <= 2'h1;
    wait_sig(0, 1'b1, 30);
    check(32'(led_on), 32'h1);
    check(32'(flash_mode), 32'h0);
    cyc(8300);
    #1;
    check(32'(duty_cmd), 32'(exp_duty(PER)));
    rd(`LSC_OFF_STATUS, d);
    cyc(1);
    shrt <= 1'b1;
    wait_sig(1, 1'b1, 10);
    check(32'(sense_on), 32'h1);
    check(32'(led_on), 32'h0);
    // Status bit lands one cycle after the sense current
    cyc(1);
    #1;
    check(32'(irq), 32'h1);
    rd(`LSC_OFF_STATUS, d);
    check(32'(d[`LSC_EVT_SHORT]), 32'h1);
    check(32'(irq), 32'h0);
    cyc(1);
    shrt <= 1'b0;
    wait_sig(0, 1'b1, 10);
    check(32'(led_on), 32'h1);
    check(32'(sense_on), 32'h0);
    cyc(1);
    uv <= 1'b1;
    stay(0, 1'b0, 20, ok);
    check(32'(ok), 32'h0);
    stay(0, 1'b0, 20, ok);
    check(32'(ok), 32'h1);
    cyc(1);
    uv <= 1'b0;
    wait_sig(0, 1'b1, 10);
    check(32'(led_on), 32'h1);
    check(32'(duty_cmd), 32'(exp_duty(PER)));
    wr(`LSC_OFF_CTRL, 32'h1);
    cyc(2);
    #1;
    check(32'(led_on), 32'h0);
    wr(`LSC_OFF_CTRL, 32'h0);
    wait_sig(0, 1'b1, 5);
    cyc(1);
    ot <= 1'b1;
    wait_sig(0, 1'b0, 10);
    check(32'(led_on), 32'h0);
    cyc(1);
    ot <= 1'b0;
    stay(0, 1'b0, 40, ok);
    check(32'(ok), 32'h1);
    cyc(1);
    mode <= 2'h0;
    stay(2, 1'b0, SHDN, ok);
    check(32'(ok), 32'h1);
    wait_sig(2, 1'b1, 40);
    check(32'(shutdown), 32'h1);
    rd(`LSC_OFF_STATE, d);
    check(32'(d[5:4]), 32'h0);
    cyc(1);
    mode <= 2'h1;
    wait_sig(0, 1'b1, 30);
    check(32'(led_on), 32'h1);
    cyc(1);
    shrt <= 1'b1;
    wait_sig(1, 1'b1, 10);
    check(32'(sense_on), 32'h1);
    cyc(1);
    shrt <= 1'b0;
    flash <= 1'b1;
    restart();
    check(32'(flash_mode), 32'h1);
    // Drop the timeout raised while waiting for the restart
    rd(`LSC_OFF_STATUS, d);
    stay(0, 1'b1, TMO - 20, ok);
    check(32'(ok), 32'h1);
    wait_sig(0, 1'b0, 40);
    stay(0, 1'b0, 50, ok);
    check(32'(ok), 32'h1);
    rd(`LSC_OFF_STATUS, d);
    check(32'(d[`LSC_EVT_TMO]), 32'h1);
    restart();
    check(32'(led_on), 32'h1);
    cyc(1);
    flash <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      lfsr = lfsr_next(lfsr);
      cyc(1);
      hi   <= (k == 0) ? 16'h0010 : 16'h0010 + 16'(lfsr % 992);
      mode <= 2'h2;
      cyc(8300);
      #1;
      check(32'(duty_cmd), 32'(exp_duty(hi)));
      check(32'(shutdown), 32'h0);
    end
    complete_run();
  end
endmodule
